// File: wtsc_consts.vh
// constants of the week timer sub-second and sub-week control block
`ifndef WTSC_CONSTS_VH
`define WTSC_CONSTS_VH

// register byte offsets
`define WTSC_OFS_CTRL 8'h00
`define WTSC_OFS_RATE 8'h10
`define WTSC_OFS_SWCTRL 8'h14
`define WTSC_OFS_SWCNT 8'h18
`define WTSC_OFS_IRQ_STAT 8'h28
`define WTSC_OFS_IRQ_MASK 8'h2c

// main control fields
`define WTSC_CTRL_WAKE_EN 6

// sub-week control fields
`define WTSC_SW_SEL_HI 9
`define WTSC_SW_SEL_LO 7
`define WTSC_SW_NORELOAD 6
`define WTSC_SW_GATE 5
`define WTSC_SW_PRES 4
`define WTSC_SW_LONG_FLAG 1
`define WTSC_SW_SHORT_FLAG 0

// sub-week counter register fields
`define WTSC_CNT_LOAD_HI 8
`define WTSC_CNT_STAT_LO 16
`define WTSC_CNT_STAT_HI 24

// interrupt status and mask bits
`define WTSC_IRQ_SUBSEC 0
`define WTSC_IRQ_LONG 1
`define WTSC_IRQ_SHORT 2
`define WTSC_IRQ_EXPIRE 3
`define WTSC_IRQ_BITS 4

// reset values
`define WTSC_RATE_RST 4'h0
`define WTSC_SEL_RST 3'h0
`define WTSC_LOAD_RST 9'h000
`define WTSC_IRQ_RST 4'h0

// timing: the block clock period, and the divider length
`define WTSC_CLK_PERIOD_NS 5
`define WTSC_DIV_BITS 15

`endif

// File: wtsc_ctrl.v
// sub-second rate and sub-week alarm control with an ahb-lite slave
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "wtsc_consts.vh"

module wtsc_ctrl #(
  parameter ADDR_W = 32,
  parameter SEL_W = 3,
  parameter LOAD_W = 9
) (
  // clock and reset
  input wire clk,
  input wire rst_b,
  // ahb-lite slave
  input wire hsel,
  input wire [ADDR_W-1:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  // pins from outside the clock domain
  input wire clk_32k_pin,
  input wire main_power_present_input,
  // same-clock inputs from the week counter and tick sources
  input wire long_alarm_reached,
  input wire [(1<<SEL_W)-1:0] short_tick_src,
  // events and interrupt
  output reg wake_event,
  output reg subsecond_event,
  output reg irq
);

  localparam DW = `WTSC_DIV_BITS;
  localparam [LOAD_W-1:0] LOAD_ONE = {{(LOAD_W-1){1'b0}}, 1'b1};

  // rate select to divider bit hit
  function rate_hit;
    input [DW-1:0] toggled;
    input [3:0] rate;
    begin
      if (rate == 4'h0) begin
        rate_hit = 1'b0;
      end else begin
        rate_hit = toggled[4'hf - rate];
      end
    end
  endfunction

  // latched address matches one register offset
  function reg_hit;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      reg_hit = (addr == ofs);
    end
  endfunction

  // register state
  reg wake_en_reg;
  reg [3:0] rate_reg;
  reg [SEL_W-1:0] sel_reg;
  reg noreload_reg;
  reg gate_reg;
  reg long_flag_reg;
  reg short_flag_reg;
  reg [LOAD_W-1:0] load_reg;
  reg [LOAD_W-1:0] count_reg;
  reg [`WTSC_IRQ_BITS-1:0] irq_stat_reg;
  reg [`WTSC_IRQ_BITS-1:0] irq_mask_reg;

  // synchronisers and divider
  reg pres_s1_reg;
  reg pres_s2_reg;
  reg c32_s1_reg;
  reg c32_s2_reg;
  reg c32_d_reg;
  reg [DW-1:0] div_reg;

  // ahb data phase state
  reg ap_valid_reg;
  reg ap_write_reg;
  reg [7:0] ap_addr_reg;

  // combinational terms
  wire ap_take;
  wire wr;
  wire wr_ctrl;
  wire wr_rate;
  wire wr_sw;
  wire wr_cnt;
  wire wr_stat;
  wire wr_mask;
  wire adv;
  wire [DW-1:0] div_inc;
  wire [DW-1:0] toggled;
  wire sub_pulse;
  wire tick;
  wire expire;
  wire long_cond;
  wire long_set;
  wire short_set;
  wire [`WTSC_IRQ_BITS-1:0] irq_ev;
  wire wake_next;
  wire wake_gate;
  wire wake_cause;
  reg [31:0] rd_mux;

  assign ap_take = hsel & htrans[1] & hready;
  assign wr = ap_valid_reg & ap_write_reg;
  assign wr_ctrl = wr & reg_hit(ap_addr_reg, `WTSC_OFS_CTRL);
  assign wr_rate = wr & reg_hit(ap_addr_reg, `WTSC_OFS_RATE);
  assign wr_sw = wr & reg_hit(ap_addr_reg, `WTSC_OFS_SWCTRL);
  assign wr_cnt = wr & reg_hit(ap_addr_reg, `WTSC_OFS_SWCNT);
  assign wr_stat = wr & reg_hit(ap_addr_reg, `WTSC_OFS_IRQ_STAT);
  assign wr_mask = wr & reg_hit(ap_addr_reg, `WTSC_OFS_IRQ_MASK);

  // divider advances on each rising 32 kHz edge
  assign adv = c32_s2_reg & ~c32_d_reg;
  assign div_inc = div_reg + {{(DW-1){1'b0}}, 1'b1};
  assign toggled = adv ? (div_reg ^ div_inc) : {DW{1'b0}};
  assign sub_pulse = rate_hit(toggled, rate_reg);

  // sub-week tick and expiry
  assign tick = short_tick_src[sel_reg];
  assign expire = tick & (count_reg == LOAD_ONE);

  // wake flags, set wins over clear
  assign long_cond = long_alarm_reached & wake_en_reg;
  assign long_set = long_cond;
  assign short_set = expire & wake_en_reg & ~wr_cnt;

  // wake output condition
  assign wake_gate = ~gate_reg | pres_s2_reg;
  assign wake_cause = long_cond | short_flag_reg;
  assign wake_next = wake_en_reg & wake_gate & wake_cause;

  assign irq_ev = {expire & ~wr_cnt, short_set, long_set, sub_pulse};

  // read multiplexer
  always @* begin
    rd_mux = 32'h0000_0000;
    case (haddr[7:0])
      `WTSC_OFS_CTRL: begin
        rd_mux[`WTSC_CTRL_WAKE_EN] = wake_en_reg;
      end
      `WTSC_OFS_RATE: begin
        rd_mux[3:0] = rate_reg;
      end
      `WTSC_OFS_SWCTRL: begin
        rd_mux[`WTSC_SW_SEL_HI:`WTSC_SW_SEL_LO] = sel_reg;
        rd_mux[`WTSC_SW_NORELOAD] = noreload_reg;
        rd_mux[`WTSC_SW_GATE] = gate_reg;
        rd_mux[`WTSC_SW_PRES] = pres_s2_reg;
        rd_mux[`WTSC_SW_LONG_FLAG] = long_flag_reg;
        rd_mux[`WTSC_SW_SHORT_FLAG] = short_flag_reg;
      end
      `WTSC_OFS_SWCNT: begin
        rd_mux[`WTSC_CNT_LOAD_HI:0] = load_reg;
        rd_mux[`WTSC_CNT_STAT_HI:`WTSC_CNT_STAT_LO] = count_reg;
      end
      `WTSC_OFS_IRQ_STAT: begin
        rd_mux[`WTSC_IRQ_BITS-1:0] = irq_stat_reg;
      end
      `WTSC_OFS_IRQ_MASK: begin
        rd_mux[`WTSC_IRQ_BITS-1:0] = irq_mask_reg;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  // ahb-lite slave, zero wait states, always okay
  always @(posedge clk) begin
    if (!rst_b) begin
      ap_valid_reg <= 1'b0;
      ap_write_reg <= 1'b0;
      ap_addr_reg <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      ap_valid_reg <= ap_take;
      ap_write_reg <= ap_take & hwrite;
      ap_addr_reg <= haddr[7:0];
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (ap_take & ~hwrite) begin
        hrdata <= rd_mux;
      end else begin
        hrdata <= 32'h0000_0000;
      end
    end
  end

  // input synchronisers and 15-bit divider
  always @(posedge clk) begin
    if (!rst_b) begin
      pres_s1_reg <= 1'b0;
      pres_s2_reg <= 1'b0;
      c32_s1_reg <= 1'b0;
      c32_s2_reg <= 1'b0;
      c32_d_reg <= 1'b0;
      div_reg <= {DW{1'b0}};
    end else begin
      pres_s1_reg <= main_power_present_input;
      pres_s2_reg <= pres_s1_reg;
      c32_s1_reg <= clk_32k_pin;
      c32_s2_reg <= c32_s1_reg;
      c32_d_reg <= c32_s2_reg;
      if (adv) begin
        div_reg <= div_inc;
      end
    end
  end

  // control registers
  always @(posedge clk) begin
    if (!rst_b) begin
      wake_en_reg <= 1'b0;
      rate_reg <= `WTSC_RATE_RST;
      sel_reg <= `WTSC_SEL_RST;
      noreload_reg <= 1'b0;
      gate_reg <= 1'b0;
      irq_mask_reg <= `WTSC_IRQ_RST;
    end else begin
      if (wr_ctrl) begin
        wake_en_reg <= hwdata[`WTSC_CTRL_WAKE_EN];
      end
      if (wr_rate) begin
        rate_reg <= hwdata[3:0];
      end
      if (wr_sw) begin
        sel_reg <= hwdata[`WTSC_SW_SEL_HI:`WTSC_SW_SEL_LO];
        noreload_reg <= hwdata[`WTSC_SW_NORELOAD];
        gate_reg <= hwdata[`WTSC_SW_GATE];
      end
      if (wr_mask) begin
        irq_mask_reg <= hwdata[`WTSC_IRQ_BITS-1:0];
      end
    end
  end

  // sub-week load value and down counter
  always @(posedge clk) begin
    if (!rst_b) begin
      load_reg <= `WTSC_LOAD_RST;
      count_reg <= `WTSC_LOAD_RST;
    end else if (wr_cnt) begin
      load_reg <= hwdata[`WTSC_CNT_LOAD_HI:0];
      count_reg <= hwdata[`WTSC_CNT_LOAD_HI:0];
    end else if (tick & (count_reg != {LOAD_W{1'b0}})) begin
      if (expire & ~noreload_reg) begin
        count_reg <= load_reg;
      end else begin
        count_reg <= count_reg - LOAD_ONE;
      end
    end
  end

  // wake flags, write one to clear, set wins
  always @(posedge clk) begin
    if (!rst_b) begin
      long_flag_reg <= 1'b0;
      short_flag_reg <= 1'b0;
    end else begin
      if (long_set) begin
        long_flag_reg <= 1'b1;
      end else if (wr_sw & hwdata[`WTSC_SW_LONG_FLAG]) begin
        long_flag_reg <= 1'b0;
      end
      if (short_set) begin
        short_flag_reg <= 1'b1;
      end else if (wr_sw & hwdata[`WTSC_SW_SHORT_FLAG]) begin
        short_flag_reg <= 1'b0;
      end
    end
  end

  // interrupt status, mask and outputs
  always @(posedge clk) begin
    if (!rst_b) begin
      irq_stat_reg <= `WTSC_IRQ_RST;
      irq <= 1'b0;
      wake_event <= 1'b0;
      subsecond_event <= 1'b0;
    end else begin
      if (wr_stat) begin
        irq_stat_reg <= (irq_stat_reg & ~hwdata[`WTSC_IRQ_BITS-1:0])
          | irq_ev;
      end else begin
        irq_stat_reg <= irq_stat_reg | irq_ev;
      end
      irq <= |(irq_stat_reg & irq_mask_reg);
      wake_event <= wake_next;
      subsecond_event <= sub_pulse;
    end
  end

endmodule // wtsc_ctrl
`default_nettype wire

// File: wtsc_chk_asserts.sv
// port checker of the week timer control block
`timescale 1ns/1ps
`default_nettype none
module wtsc_chk (
  // clock and reset
  input wire clk,
  input wire rst_b,
  // bus
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] hrdata,
  // pins and events
  input wire main_power_present_input,
  input wire wake_event,
  input wire subsecond_event,
  input wire irq
);
  wire rd;
  wire pw;
  assign rd = hsel && htrans[1] && hready && !hwrite;
  assign pw = main_power_present_input;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  resp_okay_a: assert property (!hresp)
    else $error("hresp not okay");
  zero_wait_a: assert property (hreadyout)
    else $error("wait state seen");
  idle_rdata_a: assert property (!$past(rd) |-> hrdata == 32'h0)
    else $error("hrdata not idle");
  rate_rsvd_a: assert property (
    $past(rd && haddr[7:0] == 8'h10) |-> hrdata[31:4] == 28'h0)
    else $error("rate reserved bits set");
  ctrl_rsvd_a: assert property (
    $past(rd && haddr[7:0] == 8'h14) |-> !hrdata[31:10] && !hrdata[3:2])
    else $error("control reserved bits set");
  power_level_a: assert property (
    rd && haddr[7:0] == 8'h14 && $past(pw, 2) == $past(pw, 3)
    |=> hrdata[4] == $past(pw, 3))
    else $error("power level bit wrong");
  pulse_once_a: assert property (
    subsecond_event |=> !subsecond_event)
    else $error("event longer than a cycle");
  reset_quiet_a: assert property (
    $rose(rst_b) |-> !(hrdata || irq || wake_event || subsecond_event))
    else $error("outputs busy after reset");
endmodule // wtsc_chk
bind wtsc_ctrl wtsc_chk u_chk (
  .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .main_power_present_input(main_power_present_input),
  .wake_event(wake_event), .subsecond_event(subsecond_event), .irq(irq));
`default_nettype wire

// File: tb_week_timer_subsecond_subweek_ctrl.sv
// self-checking bench of the sub-second and sub-week control block
`timescale 1ns/1ps
`default_nettype none
module tb_week_timer_subsecond_subweek_ctrl;
  logic clk, rst_b, hsel, hwrite, p32, pwr, lar, rdph;
  logic [31:0] haddr, hwdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] tick;
  logic [8:0] ld;
  logic [3:0] rn;
  wire hro, hresp, wake, sse, irq;
  wire [31:0] hrdata;
  logic [31:0] q[$];
  int fail_count, checks;
  wtsc_ctrl u_dut (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hro), .hreadyout(hro), .hresp(hresp), .hrdata(hrdata),
    .clk_32k_pin(p32), .main_power_present_input(pwr),
    .long_alarm_reached(lar), .short_tick_src(tick), .wake_event(wake),
    .subsecond_event(sse), .irq(irq));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // fast stand-in for the 32k pin, period 16 clocks
  initial begin
    p32 = 1'b0;
    forever begin
      repeat (8) @(posedge clk);
      p32 <= ~p32;
    end
  end
  task chk_rd(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %0t: read %h, expected %h", $time, g, e);
    end
  endtask
  task chk_lvl(input logic [1:0] g, input logic [1:0] e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %0t: irq and wake %b, expected %b", $time, g, e);
    end
  endtask
  task chk_gap(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %0t: event gap %0d, expected %0d", $time, g, e);
    end
  endtask
  // one ahb-lite single transfer; a read notes its expected data
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge clk);
    while (hro !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    rdph <= !w;
    if (!w) q.push_back(d);
    @(posedge clk);
    while (hro !== 1'b1) @(posedge clk);
    rdph <= 1'b0;
  endtask
  // read data taken at the edge that ends the data phase
  always @(posedge clk)
    if (rdph && hro) chk_rd(hrdata, q.pop_front());
  task ev(input logic [1:0] e);
    repeat (6) @(negedge clk);
    chk_lvl({irq, wake}, e);
  endtask
  task tk(input int i);
    @(posedge clk);
    tick <= 8'h1 << i;
    @(posedge clk);
    tick <= 8'h0;
  endtask
  // spacing of sub-second events; 600 means none seen
  task ss(input logic [3:0] n);
    int c;
    xfer(1'b1, 8'h10, {28'h0, n});
    repeat (2) begin
      c = 0;
      do begin
        @(negedge clk);
        c++;
      end while (sse !== 1'b1 && c < 600);
    end
    chk_gap(c, n ? 32'd16 << (15 - n) : 32'd600);
  endtask
  task wrap_up;
    if (fail_count == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    fail_count++;
    wrap_up;
  end
  initial begin
    void'($urandom(32'hbe1ed0bb));
    {rst_b, hsel, hwrite, pwr, lar, rdph} = 6'h0;
    {haddr, hwdata, htrans, tick} = 74'h0;
    hsize = 3'h2;
    fail_count = 0;
    checks = 0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    xfer(1'b0, 8'h10, 32'h0);
    xfer(1'b0, 8'h3c, 32'h0);
    xfer(1'b1, 8'h10, 32'hffff_fff5);
    xfer(1'b0, 8'h10, 32'h5);
    ss(4'hf);
    ss(4'hd);
    rn = $urandom_range(12, 10);
    ss(rn);
    ss(4'h0);
    xfer(1'b1, 8'h14, 32'hffff_ffdc);
    xfer(1'b0, 8'h14, 32'h3c0);
    xfer(1'b1, 8'h00, 32'h40);
    xfer(1'b1, 8'h14, 32'h100);
    ld = $urandom_range(5, 2);
    xfer(1'b1, 8'h18, {23'h0, ld});
    xfer(1'b0, 8'h18, {7'h0, ld, 7'h0, ld});
    tk(1);
    repeat (ld - 1) tk(2);
    ev(2'b00);
    tk(2);
    ev(2'b01);
    xfer(1'b0, 8'h18, {7'h0, ld, 7'h0, ld});
    xfer(1'b0, 8'h28, 32'hd);
    xfer(1'b1, 8'h2c, 32'h4);
    ev(2'b11);
    xfer(1'b1, 8'h28, 32'h4);
    ev(2'b01);
    xfer(1'b1, 8'h14, 32'h100);
    ev(2'b01);
    xfer(1'b0, 8'h14, 32'h101);
    xfer(1'b1, 8'h14, 32'h101);
    ev(2'b00);
    xfer(1'b1, 8'h14, 32'h120);
    lar <= 1'b1;
    ev(2'b00);
    pwr <= 1'b1;
    ev(2'b01);
    xfer(1'b0, 8'h14, 32'h132);
    lar <= 1'b0;
    ev(2'b00);
    xfer(1'b0, 8'h14, 32'h132);
    lar <= 1'b1;
    xfer(1'b1, 8'h00, 32'h0);
    ev(2'b00);
    xfer(1'b1, 8'h14, 32'h142);
    xfer(1'b1, 8'h18, 32'h1);
    tk(2);
    xfer(1'b0, 8'h18, 32'h1);
    xfer(1'b0, 8'h14, 32'h150);
    xfer(1'b1, 8'h18, 32'h0);
    tk(2);
    xfer(1'b0, 8'h18, 32'h0);
    wrap_up;
  end
endmodule // tb_week_timer_subsecond_subweek_ctrl
`default_nettype wire
